// ==== rtl/vas_consts.vh ====
// Constants shared by the video input autoselect design.
`ifndef VAS_CONSTS_VH
`define VAS_CONSTS_VH
`define VAS_NUM_IN 5
`define VAS_NUM_OUT 2
`define VAS_PRIO_W 7
`define VAS_PRIO_BEST 7'h01
`define VAS_PRIO_WORST 7'h64
`define VAS_PRIO_DIS 7'h00
`define VAS_PRIO_PHYS_RST 7'h32
`define VAS_PRIO_WELC_RST 7'h64
`define VAS_POL_W 2
`define VAS_POL_MANUAL 2'h0
`define VAS_POL_FIRST 2'h1
`define VAS_POL_LAST 2'h2
`define VAS_POL_RST 2'h1
`define VAS_USB_MANUAL 2'h0
`define VAS_USB_FOLLOW 2'h3
`define VAS_ADDR_W 4
`define VAS_REG_POL 4'h0
`define VAS_REG_MANUAL 4'h1
`define VAS_REG_PRIO0 4'h2
`define VAS_REG_USB 4'h4
`define VAS_REG_STATUS 4'h5
`define VAS_REG_INPUTS 4'h6
`define VAS_REG_PRIO_WELC 4'h7
`define VAS_WELC_OUT2_POS 8
`define VAS_IDX_W 3
`define VAS_IDX_NONE 3'h7
`define VAS_IDX_WELC 3'h4
`endif

// ==== rtl/vas_select.v ====
// Priority and policy based input chooser for one output.
`timescale 1ns/1ps
`default_nettype none
`include "vas_consts.vh"
module vas_select
(
  input wire [`VAS_NUM_IN-1:0] present,
  input wire [`VAS_NUM_IN-1:0] newlyActive,
  input wire [`VAS_NUM_IN*`VAS_PRIO_W-1:0] prio,
  input wire [`VAS_POL_W-1:0] policy,
  input wire [`VAS_IDX_W-1:0] current,
  output reg [`VAS_IDX_W-1:0] choice
);
  reg [`VAS_PRIO_W-1:0] bestP;
  reg [`VAS_IDX_W-1:0] bestI;
  reg [`VAS_PRIO_W-1:0] newP;
  reg [`VAS_IDX_W-1:0] newI;
  reg [`VAS_PRIO_W-1:0] curP;
  reg curOk;
  reg [`VAS_PRIO_W-1:0] p;
  integer i;
  always @*
  begin
    bestP = `VAS_PRIO_WORST;
    bestI = `VAS_IDX_NONE;
    newP = `VAS_PRIO_WORST;
    newI = `VAS_IDX_NONE;
    curP = `VAS_PRIO_WORST;
    curOk = 1'b0;
    p = `VAS_PRIO_DIS;
    // Scanning downward with <= leaves the lowest index on a tie.
    for (i = `VAS_NUM_IN - 1; i >= 0; i = i - 1)
    begin
      p = prio[i*`VAS_PRIO_W +: `VAS_PRIO_W];
      if (present[i] && p != `VAS_PRIO_DIS)
      begin
        if (p <= bestP)
        begin
          bestP = p;
          bestI = i[`VAS_IDX_W-1:0];
        end
        if (newlyActive[i] && p <= newP)
        begin
          newP = p;
          newI = i[`VAS_IDX_W-1:0];
        end
        if (i[`VAS_IDX_W-1:0] == current)
        begin
          curOk = 1'b1;
          curP = p;
        end
      end
    end
    choice = current;
    case (policy)
      `VAS_POL_FIRST:
      begin
        if (!curOk || bestP < curP)
          choice = bestI;
      end
      `VAS_POL_LAST:
      begin
        if (!curOk)
          choice = bestI;
        else if (newI != `VAS_IDX_NONE && newP <= curP)
          choice = newI;
        else if (bestP < curP)
          choice = bestI;
      end
      default:
        choice = current;
    endcase
  end
endmodule // vas_select
`default_nettype wire

// ==== rtl/vas_autoselect.v ====
// Video input autoselect for two outputs with welcome screen and USB follow.
`timescale 1ns/1ps
`default_nettype none
`include "vas_consts.vh"
module vas_autoselect
(
  input wire sys_clk,
  input wire arst_n,
  input wire clkEn,
  input wire [`VAS_ADDR_W-1:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWrEn,
  input wire regRdEn,
  output reg [31:0] regRdData_q,
  input wire [`VAS_NUM_IN-2:0] signalActiveFlag,
  input wire typecHostAttached,
  input wire typecAudioEmbedded,
  output reg [`VAS_IDX_W-1:0] outputOneRoute_q,
  output reg [`VAS_IDX_W-1:0] outputTwoRoute_q,
  output reg [`VAS_IDX_W-1:0] usbHubRoute_q,
  output reg welcomeScreenEnable_q,
  output reg audioFromTypecEnable_q,
  output reg typecAudioPresent_q
);
  localparam NI = `VAS_NUM_IN;
  localparam PW = `VAS_PRIO_W;
  localparam IW = `VAS_IDX_W;
  reg [NI-2:0] sigMeta_q;
  reg [NI-2:0] sigSync_q;
  reg [1:0] hostMeta_q;
  reg [1:0] hostSync_q;
  reg audMeta_q;
  reg audSync_q;
  reg [NI-1:0] presPrev_q;
  reg [2*`VAS_POL_W-1:0] policy_q;
  reg [NI*PW-1:0] prio_q [0:1];
  reg [1:0] usbPolicy_q;
  reg [IW-1:0] route_q [0:1];
  reg [IW-1:0] route_d [0:1];
  wire [IW-1:0] autoChoice [0:1];
  wire welcomeRouted;
  wire [NI-1:0] present;
  wire [NI-1:0] newlyActive;
  wire hostRise;
  wire manualWr;
  wire [NI*PW-1:0] prioRst;
  integer k;

  // Host attach is edge detected on the second stage only.
  assign hostRise = hostSync_q[0] && !hostSync_q[1];
  assign welcomeRouted = (route_q[0] == `VAS_IDX_WELC) || (route_q[1] == `VAS_IDX_WELC);
  // The first input cannot be sensed while the generator owns its path.
  assign present = {1'b1, sigSync_q[NI-2:1], sigSync_q[0] && !welcomeRouted};
  assign newlyActive = present & ~presPrev_q;
  assign manualWr = clkEn && regWrEn && regAddr == `VAS_REG_MANUAL;
  assign prioRst = {`VAS_PRIO_WELC_RST, {(NI-1){`VAS_PRIO_PHYS_RST}}};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : gOut
      vas_select uSel
      (
        .present(present),
        .newlyActive(newlyActive),
        .prio(prio_q[g]),
        .policy(policy_q[g*`VAS_POL_W +: `VAS_POL_W]),
        .current(route_q[g]),
        .choice(autoChoice[g])
      );
    end
  endgenerate

  always @*
  begin
    for (k = 0; k < 2; k = k + 1)
    begin
      route_d[k] = autoChoice[k];
      if (manualWr && regWrData[4*k+3] &&
          (regWrData[4*k +: IW] <= `VAS_IDX_WELC || regWrData[4*k +: IW] == `VAS_IDX_NONE))
        route_d[k] = regWrData[4*k +: IW];
    end
    if (hostSync_q[0] && policy_q[`VAS_POL_W-1:0] != `VAS_POL_MANUAL)
    begin
      // Attaching a host wins output one even without video on it. Testing the
      // candidate keeps a silent host from letting the generator return one cycle after the attach.
      if (hostRise || route_d[0] == `VAS_IDX_WELC)
      begin
        route_d[0] = {IW{1'b0}};
        if (route_d[1] == `VAS_IDX_WELC)
          route_d[1] = `VAS_IDX_NONE;
      end
    end
    // A request that would pair the first input with the generator keeps the
    // older route, since the two share one receiver path.
    if ((route_d[0] == {IW{1'b0}} && route_d[1] == `VAS_IDX_WELC) ||
        (route_d[1] == {IW{1'b0}} && route_d[0] == `VAS_IDX_WELC))
    begin
      if (route_d[1] != route_q[1])
        route_d[1] = route_q[1];
      else
        route_d[0] = route_q[0];
    end
    if ((route_d[0] == {IW{1'b0}} && route_d[1] == `VAS_IDX_WELC) ||
        (route_d[1] == {IW{1'b0}} && route_d[0] == `VAS_IDX_WELC))
      route_d[1] = `VAS_IDX_NONE;
  end

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sigMeta_q <= {(NI-1){1'b0}};
      sigSync_q <= {(NI-1){1'b0}};
      hostMeta_q <= 2'h0;
      hostSync_q <= 2'h0;
      audMeta_q <= 1'b0;
      audSync_q <= 1'b0;
      presPrev_q <= {NI{1'b0}};
      policy_q <= {`VAS_POL_RST, `VAS_POL_RST};
      prio_q[0] <= {NI*PW{1'b0}};
      prio_q[1] <= {NI*PW{1'b0}};
      usbPolicy_q <= `VAS_USB_MANUAL;
      route_q[0] <= `VAS_IDX_NONE;
      route_q[1] <= `VAS_IDX_NONE;
      usbHubRoute_q <= `VAS_IDX_NONE;
      outputOneRoute_q <= `VAS_IDX_NONE;
      outputTwoRoute_q <= `VAS_IDX_NONE;
      welcomeScreenEnable_q <= 1'b0;
      audioFromTypecEnable_q <= 1'b0;
      typecAudioPresent_q <= 1'b0;
      regRdData_q <= 32'h0;
    end
    else if (clkEn)
    begin
      sigMeta_q <= signalActiveFlag;
      sigSync_q <= sigMeta_q;
      hostMeta_q <= {hostMeta_q[0], typecHostAttached};
      hostSync_q <= {hostSync_q[0], hostMeta_q[1]};
      audMeta_q <= typecAudioEmbedded;
      audSync_q <= audMeta_q;
      presPrev_q <= present;
      route_q[0] <= route_d[0];
      route_q[1] <= route_d[1];
      outputOneRoute_q <= route_d[0];
      outputTwoRoute_q <= route_d[1];
      welcomeScreenEnable_q <= (route_d[0] == `VAS_IDX_WELC) || (route_d[1] == `VAS_IDX_WELC);
      audioFromTypecEnable_q <= !((route_d[0] == `VAS_IDX_WELC) || (route_d[1] == `VAS_IDX_WELC));
      typecAudioPresent_q <= audSync_q && !welcomeRouted;
      if (usbPolicy_q == `VAS_USB_FOLLOW)
        usbHubRoute_q <= (route_d[0] == `VAS_IDX_WELC) ? `VAS_IDX_NONE : route_d[0];
      else if (regWrEn && regAddr == `VAS_REG_USB &&
               (regWrData[IW+1:2] < `VAS_IDX_WELC || regWrData[IW+1:2] == `VAS_IDX_NONE))
        usbHubRoute_q <= regWrData[IW+1:2];
      if (!presPrev_q[NI-1] && prio_q[0] == {NI*PW{1'b0}})
      begin
        // Priorities take their defaults in the first cycle after reset.
        prio_q[0] <= prioRst;
        prio_q[1] <= prioRst;
      end
      if (regWrEn)
      begin
        case (regAddr)
          `VAS_REG_POL: policy_q <= regWrData[2*`VAS_POL_W-1:0];
          `VAS_REG_PRIO0: prio_q[0][(NI-1)*PW-1:0] <= regWrData[(NI-1)*PW-1:0];
          `VAS_REG_PRIO0 + 4'h1: prio_q[1][(NI-1)*PW-1:0] <= regWrData[(NI-1)*PW-1:0];
          // Welcome priorities live apart, since five seven-bit fields overflow the data word.
          `VAS_REG_PRIO_WELC:
          begin
            prio_q[0][NI*PW-1 -: PW] <= regWrData[PW-1:0];
            prio_q[1][NI*PW-1 -: PW] <= regWrData[`VAS_WELC_OUT2_POS +: PW];
          end
          `VAS_REG_USB: usbPolicy_q <= regWrData[1:0];
          default: policy_q <= policy_q;
        endcase
      end
      regRdData_q <= 32'h0;
      if (regRdEn)
      begin
        case (regAddr)
          `VAS_REG_POL: regRdData_q <= {28'h0, policy_q};
          `VAS_REG_MANUAL: regRdData_q <= {24'h0, 1'b0, route_q[1], 1'b0, route_q[0]};
          `VAS_REG_PRIO0: regRdData_q <= {{(32-(NI-1)*PW){1'b0}}, prio_q[0][(NI-1)*PW-1:0]};
          `VAS_REG_PRIO0 + 4'h1: regRdData_q <= {{(32-(NI-1)*PW){1'b0}}, prio_q[1][(NI-1)*PW-1:0]};
          `VAS_REG_PRIO_WELC: regRdData_q <= {{(32-`VAS_WELC_OUT2_POS-PW){1'b0}}, prio_q[1][NI*PW-1 -: PW],
            {(`VAS_WELC_OUT2_POS-PW){1'b0}}, prio_q[0][NI*PW-1 -: PW]};
          `VAS_REG_USB: regRdData_q <= {27'h0, usbHubRoute_q, usbPolicy_q};
          `VAS_REG_STATUS: regRdData_q <= {29'h0, typecAudioPresent_q, welcomeScreenEnable_q, hostSync_q[0]};
          `VAS_REG_INPUTS: regRdData_q <= {27'h0, present};
          default: regRdData_q <= 32'h0;
        endcase
      end
    end
  end
endmodule // vas_autoselect
`default_nettype wire

// ==== tb/vas_src_model.sv ====
// Model of the video sources that raise the signal-present lines.
`timescale 1ns/1ps
`default_nettype none
module vas_src_model
(
  input wire logic sys_clk,
  input wire logic [3:0] plug,
  output logic [3:0] signalActiveFlag
);
  initial signalActiveFlag = 4'h0;
  // A source shows its signal a clock after the cable goes in, never at once.
  always @(posedge sys_clk)
  begin
    signalActiveFlag <= plug;
  end
endmodule // vas_src_model
`default_nettype wire

// ==== tb/vas_autoselect_chk.sv ====
// Port assertions for the video input autoselect block.
`timescale 1ns/1ps
`default_nettype none
module vas_autoselect_chk
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic typecHostAttached,
  input wire logic typecAudioEmbedded,
  input wire logic [2:0] outputOneRoute_q,
  input wire logic [2:0] outputTwoRoute_q,
  input wire logic [2:0] usbHubRoute_q,
  input wire logic welcomeScreenEnable_q,
  input wire logic audioFromTypecEnable_q,
  input wire logic typecAudioPresent_q
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  // Five quiet cycles cover the two-stage synchroniser plus the output register.
  sequence s_quiet;
    (!welcomeScreenEnable_q && $stable(typecAudioEmbedded)) [*5];
  endsequence
  sequence s_host;
    typecHostAttached [*6];
  endsequence
  property p_excl;
    {outputOneRoute_q, outputTwoRoute_q} != 6'h04 && {outputOneRoute_q, outputTwoRoute_q} != 6'h20;
  endproperty
  property p_welc;
    welcomeScreenEnable_q == (outputOneRoute_q == 3'h4 || outputTwoRoute_q == 3'h4);
  endproperty
  property p_block;
    welcomeScreenEnable_q && $past(welcomeScreenEnable_q) |-> !audioFromTypecEnable_q && !typecAudioPresent_q;
  endproperty
  property p_pass;
    s_quiet |-> audioFromTypecEnable_q && typecAudioPresent_q == typecAudioEmbedded;
  endproperty
  property p_host;
    $rose(typecHostAttached) |-> ##[1:6] outputOneRoute_q == 3'h0;
  endproperty
  property p_hostStop;
    s_host |-> outputOneRoute_q != 3'h4;
  endproperty
  property p_range;
    (outputOneRoute_q <= 3'h4 || outputOneRoute_q == 3'h7) && (outputTwoRoute_q <= 3'h4 || outputTwoRoute_q == 3'h7);
  endproperty
  property p_usb;
    usbHubRoute_q <= 3'h3 || usbHubRoute_q == 3'h7;
  endproperty
  a_excl: assert property (p_excl) else $error("input one and welcome routed together");
  a_welc: assert property (p_welc) else $error("welcome enable disagrees with routes");
  a_block: assert property (p_block) else $error("input one audio open during welcome");
  a_pass: assert property (p_pass) else $error("input one audio not passed");
  a_host: assert property (p_host) else $error("host attach did not route input one");
  a_hostStop: assert property (p_hostStop) else $error("welcome kept on output one with host");
  a_range: assert property (p_range) else $error("route index out of range");
  a_usb: assert property (p_usb) else $error("usb route out of range");
endmodule // vas_autoselect_chk
bind vas_autoselect vas_autoselect_chk u_chk (.sys_clk, .arst_n, .typecHostAttached, .typecAudioEmbedded,
  .outputOneRoute_q, .outputTwoRoute_q, .usbHubRoute_q, .welcomeScreenEnable_q, .audioFromTypecEnable_q,
  .typecAudioPresent_q);
`default_nettype wire

// ==== tb/tb_vas_autoselect.sv ====
// Testbench for the video input autoselect block.
`timescale 1ns/1ps
`default_nettype none
module tb_vas_autoselect;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic host = 1'b0;
  logic audio = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWrData = 32'h0;
  logic [3:0] plug = 4'h0;
  wire [3:0] flags;
  wire [31:0] rdData;
  wire [2:0] o1, o2, usbR;
  wire welc, audEn, audPres;
  int failures = 0;
  int n_checks = 0;
  always #2 sys_clk = ~sys_clk;
  vas_src_model src (.sys_clk, .plug, .signalActiveFlag(flags));
  vas_autoselect dut (.sys_clk, .arst_n, .clkEn(1'b1), .regAddr, .regWrData, .regWrEn, .regRdEn,
    .regRdData_q(rdData), .signalActiveFlag(flags), .typecHostAttached(host), .typecAudioEmbedded(audio),
    .outputOneRoute_q(o1), .outputTwoRoute_q(o2), .usbHubRoute_q(usbR), .welcomeScreenEnable_q(welc),
    .audioFromTypecEnable_q(audEn), .typecAudioPresent_q(audPres));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    #1 chk("read data", rdData, exp);
  endtask
  // Six edges cover the source, the synchroniser and the route register.
  task automatic srcSet(input logic [3:0] p);
    @(posedge sys_clk);
    plug <= p;
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic r1(input logic [2:0] e);
    #1 chk("route one", {29'h0, o1}, {29'h0, e});
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    summarize();
  end
  initial
  begin
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(4'h2, {4'h0, 7'h32, 7'h32, 7'h32, 7'h32});
    rd(4'h7, 32'h6464);
    audio <= 1'b1;
    srcSet(4'h1);
    r1(3'h4);
    chk("audio present", {31'h0, audPres}, 32'h0);
    chk("audio path", {31'h0, audEn}, 32'h0);
    rd(4'h5, 32'h2);
    srcSet(4'h5);
    r1(3'h2);
    host <= 1'b1;
    repeat (6) @(posedge sys_clk);
    r1(3'h0);
    rd(4'h5, 32'h5);
    wr(4'h1, 32'hc0);
    #1 chk("pairing", {31'h0, o2 == 3'h4}, 32'h0);
    $display("test welcome and host done");
    @(posedge sys_clk);
    host <= 1'b0;
    audio <= 1'b0;
    // Welcome is switched off here so later ties never meet the pairing limit.
    wr(4'h2, {4'h0, 7'h14, 7'h32, 7'h32, 7'h32});
    wr(4'h3, {4'h0, 7'h14, 7'h32, 7'h32, 7'h32});
    wr(4'h7, 32'h0);
    rd(4'h2, {4'h0, 7'h14, 7'h32, 7'h32, 7'h32});
    srcSet(4'h0);
    r1(3'h7);
    srcSet(4'h6);
    r1(3'h1);
    srcSet(4'h7);
    r1(3'h1);
    srcSet(4'hf);
    r1(3'h3);
    srcSet(4'h7);
    r1(3'h0);
    wr(4'h4, 32'h1f);
    repeat (3) @(posedge sys_clk);
    #1 chk("usb route", {29'h0, usbR}, 32'h0);
    $display("test first detect done");
    wr(4'h0, 32'h6);
    rd(4'h0, 32'h6);
    srcSet(4'h3);
    r1(3'h0);
    srcSet(4'h7);
    r1(3'h2);
    wr(4'h2, {4'h0, 7'h00, 7'h32, 7'h32, 7'h32});
    srcSet(4'h8);
    r1(3'h7);
    $display("test last detect done");
    wr(4'h0, 32'h4);
    wr(4'h1, 32'h0a);
    r1(3'h2);
    srcSet(4'h2);
    r1(3'h2);
    wr(4'h0, 32'h5);
    wr(4'h2, {4'h0, 7'h14, 7'h32, 7'h32, 7'h32});
    srcSet(4'h6);
    wr(4'h1, 32'h0a);
    r1(3'h2);
    srcSet(4'he);
    r1(3'h3);
    $display("test manual done");
    summarize();
  end
endmodule // tb_vas_autoselect
`default_nettype wire
